// ---- rtl/ccc_consts.svh ----
`ifndef CCC_CONSTS_SVH
`define CCC_CONSTS_SVH

// Register byte offsets.
`define CCC_OFF_FRM_INTERVAL  12'h190
`define CCC_OFF_ACC_LIVE      12'h194
`define CCC_OFF_CONTROL       12'h240
`define CCC_OFF_FORMAT        12'h244
`define CCC_OFF_GEOMETRY      12'h248
`define CCC_OFF_SCALE         12'h24C
`define CCC_OFF_FIFO0_ADDR    12'h250
`define CCC_OFF_FIFO1_ADDR    12'h258
`define CCC_OFF_FIFO2_ADDR    12'h260
`define CCC_OFF_STATUS        12'h26C
`define CCC_OFF_EVENTS        12'h274

// Reset values.
`define CCC_RST_FORMAT        32'h0030_0200
`define CCC_RST_GEOMETRY      32'h01E0_0500
`define CCC_RST_ZERO          32'h0000_0000

// Format register fields.
`define CCC_F_PAD             31:24
`define CCC_F_INFMT           23:20
`define CCC_F_OUTFMT          19:16
`define CCC_F_VFLIP           13
`define CCC_F_HFLIP           12
`define CCC_F_FIELD           11:10
`define CCC_F_ORDER           9:8
`define CCC_M_FORMAT          32'hFFFF_3F00

// Geometry register fields: bytes per line and lines per frame.
`define CCC_F_LINE_LEN        12:0
`define CCC_F_FRAME_LINES     28:16

// Control register bits.
`define CCC_B_VIDEO_EN        0
`define CCC_B_STILL_REQ       1
`define CCC_B_EMBED_SYNC      2

// Count fields.
`define CCC_F_ACC             31:24
`define CCC_F_LIVE            23:0

// Event flag bits, write one to clear.
`define CCC_B_CAP_DONE        0
`define CCC_B_FRM_DONE        1

// Output format codes that need special handling.
`define CCC_OUT_FIELD_PRGB    4'h6
`define CCC_OUT_FRAME_PRGB    4'hE
`define CCC_OUT_FRAME_P420    4'h2

`endif

// ---- rtl/ccc_pkg.sv ----
package ccc_pkg;

   typedef enum logic [3:0] {
      CCC_IN_RAW    = 4'h0,
      CCC_IN_YUV422 = 4'h3,
      CCC_IN_YUV420 = 4'h4
   } ccc_infmt_t;

   typedef enum logic [1:0] {
      CCC_FIFO_Y,
      CCC_FIFO_U,
      CCC_FIFO_V
   } ccc_fifo_t;

   typedef enum logic [1:0] {
      CCC_FRAME_IDLE,
      CCC_FRAME_RUN,
      CCC_FRAME_FIELD1
   } ccc_frame_t;

endpackage : ccc_pkg

// ---- rtl/ccc_capture_ctrl.sv ----
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "ccc_consts.svh"

module ccc_capture_ctrl
   import ccc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ref_clk_24m,
   input  wire logic        cam_pclk,
   input  wire logic        cam_vsync,
   input  wire logic        cam_href,
   input  wire logic        cam_field,
   input  wire logic [7:0]  cam_data,
   output logic             pix_valid,
   output logic [1:0]       pix_fifo,
   output logic [31:0]      pix_addr,
   output logic [31:0]      pix_data
);

   // Pin synchroniser: every sensor pin and the reference clock.
   logic [12:0] sync1_r;
   logic [12:0] sync2_r;
   logic        ref_prev_r;
   logic        pck_prev_r;
   logic        vs_prev_r;
   logic        href_prev_r;

   // Software-side registers.
   logic [31:0] format_r;
   logic [31:0] geometry_r;
   logic        quarter_r;
   logic [31:0] fifo_addr_r [3];
   logic [2:0]  control_r;
   logic [1:0]  events_r;

   // Frame-side shadows, loaded at a frame boundary.
   logic [31:0] sh_format_r;
   logic [31:0] sh_geometry_r;
   logic        sh_quarter_r;
   logic        sh_embed_r;
   logic [31:0] sh_addr_r [3];

   logic [23:0] live_cnt_r;
   logic [23:0] interval_r;
   logic [7:0]  acc_cnt_r;
   logic        vbusy_r;
   logic        sbusy_r;
   ccc_frame_t  frame_r;
   ccc_frame_t  frame_nxt;
   logic [12:0] col_r;
   logic [12:0] line_r;
   logic [12:0] elem_r [3];
   logic [15:0] pack_r;
   logic [1:0]  pack_cnt_r;

   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        pix_valid_r;
   logic [1:0]  pix_fifo_r;
   logic [31:0] pix_addr_r;
   logic [31:0] pix_data_r;

   // Synchronised pins; only second-stage bits are read below.
   wire logic       s_ref   = sync2_r[12];
   wire logic       s_pck   = sync2_r[11];
   wire logic       s_vs    = sync2_r[10];
   wire logic       s_href  = sync2_r[9];
   wire logic       s_field = sync2_r[8];
   wire logic [7:0] s_data  = sync2_r[7:0];
   wire logic ref_rise = s_ref & ~ref_prev_r;
   wire logic pck_rise = s_pck & ~pck_prev_r;
   wire logic vs_rise  = s_vs & ~vs_prev_r;
   wire logic line_end = ~s_href & href_prev_r;

   // APB decode.
   wire logic acc_ph  = psel & penable;
   wire logic wr_ev   = acc_ph & pwrite & pready_r;
   wire logic hit_int = paddr == `CCC_OFF_FRM_INTERVAL;
   wire logic hit_acc = paddr == `CCC_OFF_ACC_LIVE;
   wire logic hit_ctl = paddr == `CCC_OFF_CONTROL;
   wire logic hit_fmt = paddr == `CCC_OFF_FORMAT;
   wire logic hit_geo = paddr == `CCC_OFF_GEOMETRY;
   wire logic hit_scl = paddr == `CCC_OFF_SCALE;
   wire logic hit_a0  = paddr == `CCC_OFF_FIFO0_ADDR;
   wire logic hit_a1  = paddr == `CCC_OFF_FIFO1_ADDR;
   wire logic hit_a2  = paddr == `CCC_OFF_FIFO2_ADDR;
   wire logic hit_sta = paddr == `CCC_OFF_STATUS;
   wire logic hit_evt = paddr == `CCC_OFF_EVENTS;
   wire logic mapped  = hit_int | hit_acc | hit_ctl | hit_fmt | hit_geo
                      | hit_scl | hit_a0 | hit_a1 | hit_a2 | hit_sta
                      | hit_evt;
   wire logic [2:0] hit_addr = {hit_a2, hit_a1, hit_a0};

   wire logic acc_clr = wr_ev & hit_acc & (pwdata == `CCC_RST_ZERO);

   wire logic [31:0] rd_mux =
        hit_int ? {8'h00, interval_r}
      : hit_acc ? {acc_cnt_r, live_cnt_r}
      : hit_ctl ? {29'h0000_0000, control_r}
      : hit_fmt ? format_r
      : hit_geo ? geometry_r
      : hit_scl ? {31'h0000_0000, quarter_r}
      : hit_a0  ? fifo_addr_r[0]
      : hit_a1  ? fifo_addr_r[1]
      : hit_a2  ? fifo_addr_r[2]
      : hit_sta ? {29'h0000_0000, s_field, vbusy_r, sbusy_r}
      : hit_evt ? {30'h0000_0000, events_r}
      : `CCC_RST_ZERO;

   // Format legality for the active shadow configuration.
   wire logic [3:0] in_fmt  = sh_format_r[`CCC_F_INFMT];
   wire logic [3:0] out_fmt = sh_format_r[`CCC_F_OUTFMT];
   wire logic is_raw = in_fmt == CCC_IN_RAW;
   wire logic is_422 = in_fmt == CCC_IN_YUV422;
   wire logic is_420 = in_fmt == CCC_IN_YUV420;
   wire logic ok_raw = is_raw & (out_fmt[2:0] != 3'h3);
   wire logic ok_422 = is_422 & (out_fmt[3:1] != 3'h7);
   wire logic ok_420 = is_420 & (out_fmt[1:0] != 2'h0)
                     & (out_fmt[1:0] != 2'h3)
                     & ((out_fmt[3:2] != 2'h3) | (out_fmt[1:0] == 2'h1));
   wire logic fmt_ok = ok_raw | ok_422 | ok_420;
   wire logic prgb   = is_raw & ((out_fmt == `CCC_OUT_FIELD_PRGB)
                              | (out_fmt == `CCC_OUT_FRAME_PRGB));

   wire logic two_field = sh_embed_r & ~is_raw
                        & (out_fmt == `CCC_OUT_FRAME_P420);
   // The vsync that closes field one of a two-field frame is no boundary.
   wire logic boundary  = vs_rise
                        & ~((frame_r == CCC_FRAME_RUN) & two_field);
   wire logic frame_end = boundary & (frame_r != CCC_FRAME_IDLE);

   wire logic vbusy_nxt = boundary ? control_r[`CCC_B_VIDEO_EN]
                        : vbusy_r;
   wire logic sbusy_nxt = boundary ? control_r[`CCC_B_STILL_REQ]
                        : sbusy_r;
   wire logic fd_set = frame_end & vbusy_r & control_r[`CCC_B_VIDEO_EN];
   wire logic cd_set = frame_end
                     & (sbusy_r | (vbusy_r & ~control_r[`CCC_B_VIDEO_EN]));

   always_comb
   begin
      frame_nxt = frame_r;
      case (frame_r)
         CCC_FRAME_IDLE:
            if (boundary & (vbusy_nxt | sbusy_nxt))
               frame_nxt = CCC_FRAME_RUN;
         CCC_FRAME_RUN:
            if (vs_rise & two_field)
               frame_nxt = CCC_FRAME_FIELD1;
            else if (boundary & ~(vbusy_nxt | sbusy_nxt))
               frame_nxt = CCC_FRAME_IDLE;
         CCC_FRAME_FIELD1:
            if (vs_rise)
               frame_nxt = CCC_FRAME_RUN;
         default:
            frame_nxt = CCC_FRAME_IDLE;
      endcase
   end

   wire logic [1:0] fsel = sh_format_r[`CCC_F_FIELD];
   wire logic field_ok = (fsel == 2'h2) | ((fsel == 2'h0) & ~s_field)
                       | ((fsel == 2'h1) & s_field);

   wire logic keep_line = ~sh_quarter_r | ~line_r[0];
   wire logic keep_col  = ~sh_quarter_r
                        | (is_raw ? ~col_r[0] : ~col_r[2]);
   wire logic capturing = (frame_r != CCC_FRAME_IDLE) & (vbusy_r | sbusy_r);
   wire logic take = pck_rise & s_href & capturing & field_ok & fmt_ok
                   & keep_line & keep_col;

   wire logic [1:0] order = sh_format_r[`CCC_F_ORDER];
   wire logic is_y = col_r[0] == order[1];
   wire logic is_u = ~is_y & ((col_r[1] ^ order[0]) == 1'b0);
   wire ccc_fifo_t fifo_sel = (is_raw | is_y) ? CCC_FIFO_Y
                            : is_u ? CCC_FIFO_U : CCC_FIFO_V;
   wire logic emit = take & (~prgb | (pack_cnt_r == 2'h2));

   wire logic [31:0] word = prgb
        ? {sh_format_r[`CCC_F_PAD], pack_r, s_data}
        : {24'h00_0000, s_data};

   wire logic [12:0] frame_lines = sh_geometry_r[`CCC_F_FRAME_LINES];
   wire logic [12:0] line_len    = sh_geometry_r[`CCC_F_LINE_LEN];
   wire logic [12:0] row = sh_format_r[`CCC_F_VFLIP]
                         ? frame_lines - 13'h0001 - line_r : line_r;
   wire logic [12:0] elem = elem_r[fifo_sel];
   wire logic [12:0] pos  = sh_format_r[`CCC_F_HFLIP]
                          ? line_len - 13'h0001 - elem : elem;
   wire logic [25:0] row_off = row * line_len;
   wire logic [31:0] dest = sh_addr_r[fifo_sel]
                          + {6'h00, row_off} + {19'h0_0000, pos};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_r     <= 13'h0000;
         sync2_r     <= 13'h0000;
         ref_prev_r  <= 1'b0;
         pck_prev_r  <= 1'b0;
         vs_prev_r   <= 1'b0;
         href_prev_r <= 1'b0;
      end
      else
      begin
         sync1_r     <= {ref_clk_24m, cam_pclk, cam_vsync, cam_href,
                         cam_field, cam_data};
         sync2_r     <= sync1_r;
         ref_prev_r  <= s_ref;
         pck_prev_r  <= s_pck;
         vs_prev_r   <= s_vs;
         href_prev_r <= s_href;
      end
   end

   // Bus answer: one wait state, so read data and pready come from flops.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r  <= 1'b0;
         prdata_r  <= `CCC_RST_ZERO;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r  <= acc_ph & ~pready_r;
         prdata_r  <= rd_mux;
         pslverr_r <= acc_ph & ~pready_r & ~mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         format_r   <= `CCC_RST_FORMAT;
         geometry_r <= `CCC_RST_GEOMETRY;
         quarter_r  <= 1'b0;
         control_r  <= 3'h0;
      end
      else
      begin
         if (wr_ev & hit_fmt)
            format_r <= pwdata & `CCC_M_FORMAT;
         if (wr_ev & hit_geo)
            geometry_r <= {3'h0, pwdata[`CCC_F_FRAME_LINES], 3'h0,
                           pwdata[`CCC_F_LINE_LEN]};
         if (wr_ev & hit_scl)
            quarter_r <= pwdata[0];
         // The still request is consumed at the next frame boundary.
         if (wr_ev & hit_ctl)
            control_r <= pwdata[2:0];
         else if (boundary)
            control_r[`CCC_B_STILL_REQ] <= 1'b0;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_fifo
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               fifo_addr_r[gi] <= `CCC_RST_ZERO;
               sh_addr_r[gi]   <= `CCC_RST_ZERO;
               elem_r[gi]      <= 13'h0000;
            end
            else
            begin
               if (wr_ev & hit_addr[gi])
                  fifo_addr_r[gi] <= pwdata;
               if (boundary)
                  sh_addr_r[gi] <= fifo_addr_r[gi];
               if (line_end | vs_rise)
                  elem_r[gi] <= 13'h0000;
               else if (emit & (fifo_sel == ccc_fifo_t'(gi)))
                  elem_r[gi] <= elem_r[gi] + 13'h0001;
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         live_cnt_r <= 24'h00_0000;
         interval_r <= 24'h00_0000;
         acc_cnt_r  <= 8'h00;
      end
      else
      begin
         if (vs_rise)
         begin
            interval_r <= live_cnt_r;
            live_cnt_r <= 24'h00_0000;
         end
         else if (ref_rise)
            live_cnt_r <= live_cnt_r + 24'h00_0001;
         // frame count
         // A frame in the clearing cycle still counts.
         if (vs_rise)
            acc_cnt_r <= acc_clr ? 8'h01 : acc_cnt_r + 8'h01;
         else if (acc_clr)
            acc_cnt_r <= 8'h00;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sh_format_r   <= `CCC_RST_FORMAT;
         sh_geometry_r <= `CCC_RST_GEOMETRY;
         sh_quarter_r  <= 1'b0;
         sh_embed_r    <= 1'b0;
         vbusy_r       <= 1'b0;
         sbusy_r       <= 1'b0;
         frame_r       <= CCC_FRAME_IDLE;
         events_r      <= 2'h0;
      end
      else
      begin
         if (boundary)
         begin
            sh_format_r   <= format_r;
            sh_geometry_r <= geometry_r;
            sh_quarter_r  <= quarter_r;
            sh_embed_r    <= control_r[`CCC_B_EMBED_SYNC];
         end
         vbusy_r  <= vbusy_nxt;
         sbusy_r  <= sbusy_nxt;
         frame_r  <= frame_nxt;
         // Hardware set wins over a same-cycle software clear.
         events_r[`CCC_B_FRM_DONE] <= fd_set | (events_r[`CCC_B_FRM_DONE]
            & ~(wr_ev & hit_evt & pwdata[`CCC_B_FRM_DONE]));
         events_r[`CCC_B_CAP_DONE] <= cd_set | (events_r[`CCC_B_CAP_DONE]
            & ~(wr_ev & hit_evt & pwdata[`CCC_B_CAP_DONE]));
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         col_r       <= 13'h0000;
         line_r      <= 13'h0000;
         pack_r      <= 16'h0000;
         pack_cnt_r  <= 2'h0;
         pix_valid_r <= 1'b0;
         pix_fifo_r  <= 2'h0;
         pix_addr_r  <= `CCC_RST_ZERO;
         pix_data_r  <= `CCC_RST_ZERO;
      end
      else
      begin
         if (vs_rise)
         begin
            col_r  <= 13'h0000;
            line_r <= 13'h0000;
         end
         else if (line_end)
         begin
            col_r  <= 13'h0000;
            line_r <= line_r + 13'h0001;
         end
         else if (pck_rise & s_href)
            col_r <= col_r + 13'h0001;
         // Bytes of a padded pixel gather here until the third arrives.
         if (vs_rise | line_end)
            pack_cnt_r <= 2'h0;
         else if (take & prgb)
         begin
            pack_r     <= {pack_r[7:0], s_data};
            pack_cnt_r <= (pack_cnt_r == 2'h2) ? 2'h0
                        : pack_cnt_r + 2'h1;
         end
         pix_valid_r <= emit;
         if (emit)
         begin
            pix_fifo_r <= fifo_sel;
            pix_addr_r <= dest;
            pix_data_r <= word;
         end
      end
   end

   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = pslverr_r;
   assign pix_valid = pix_valid_r;
   assign pix_fifo  = pix_fifo_r;
   assign pix_addr  = pix_addr_r;
   assign pix_data  = pix_data_r;

endmodule : ccc_capture_ctrl

// ---- sim/ccc_capture_ctrl_props.sv ----
`timescale 1ns/10ps
`include "ccc_consts.svh"
module ccc_capture_ctrl_props
   import ccc_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        ref_clk_24m,
   input wire logic        cam_pclk,
   input wire logic        cam_vsync,
   input wire logic        cam_href,
   input wire logic        cam_field,
   input wire logic [7:0]  cam_data,
   input wire logic        pix_valid,
   input wire logic [1:0]  pix_fifo,
   input wire logic [31:0] pix_addr,
   input wire logic [31:0] pix_data
);
   // The format copy assumes software only rewrites it between frames.
   logic [31:0] fmt_r;
   logic [3:0]  href_age_r;
   wire logic       rd_done = psel && penable && pready && !pwrite;
   wire logic [3:0] fi      = fmt_r[`CCC_F_INFMT];
   wire logic [3:0] fo      = fmt_r[`CCC_F_OUTFMT];
   wire logic       raw_in  = (fi == 4'h0);
   wire logic       prgb    = raw_in && (fo[2:0] == 3'h6);
   wire logic       fmt_bad = raw_in ? (fo[2:0] == 3'h3) :
                              (fi == 4'h3) ? (fo[3:1] == 3'h7) :
                              (fi == 4'h4) ? !(fo inside {4'h1, 4'h2,
                              4'h5, 4'h6, 4'h9, 4'hA, 4'hD}) : 1'b1;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         fmt_r <= `CCC_RST_FORMAT;
      else if (psel && penable && pready && pwrite &&
               paddr == `CCC_OFF_FORMAT)
         fmt_r <= pwdata & `CCC_M_FORMAT;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         href_age_r <= 4'hF;
      else if (cam_href)
         href_age_r <= 4'h0;
      else if (href_age_r != 4'hF)
         href_age_r <= href_age_r + 4'h1;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_ready_wait: assert property (
      psel && penable && !pready |=> pready) else $error("pready late");
   chk_ready_pulse: assert property (
      pready |=> !pready) else $error("pready too long");
   chk_interval_top: assert property (
      rd_done && paddr == `CCC_OFF_FRM_INTERVAL |-> prdata[31:24] == 8'h00)
      else $error("interval upper byte set");
   chk_status_top: assert property (
      rd_done && paddr == `CCC_OFF_STATUS |-> prdata[31:3] == 29'h0)
      else $error("status reserved bits set");
   chk_pix_pulse: assert property (
      pix_valid |=> !pix_valid) else $error("pix_valid too long");
   chk_pix_hold: assert property (
      !pix_valid |-> $stable(pix_data) && $stable(pix_addr))
      else $error("pixel word moved without pix_valid");
   chk_raw_fifo: assert property (
      pix_valid && raw_in |-> pix_fifo == 2'h0) else $error("raw fifo");
   chk_pad_byte: assert property (
      pix_valid && prgb |-> pix_data[31:24] == fmt_r[`CCC_F_PAD])
      else $error("padding byte wrong");
   chk_rsvd_quiet: assert property (
      pix_valid |-> !fmt_bad) else $error("output on reserved format");
   chk_href_cause: assert property (
      pix_valid |-> href_age_r < 4'hC) else $error("pixel without line");
endmodule : ccc_capture_ctrl_props

bind ccc_capture_ctrl ccc_capture_ctrl_props u_props (.pclk(pclk),
   .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .ref_clk_24m(ref_clk_24m), .cam_pclk(cam_pclk),
   .cam_vsync(cam_vsync), .cam_href(cam_href), .cam_field(cam_field),
   .cam_data(cam_data), .pix_valid(pix_valid), .pix_fifo(pix_fifo),
   .pix_addr(pix_addr), .pix_data(pix_data));

// ---- sim/ccc_sensor_model.sv ----
`timescale 1ns/10ps
module ccc_sensor_model (
   output logic       cam_pclk,
   output logic       cam_vsync,
   output logic       cam_href,
   output logic       cam_field,
   output logic [7:0] cam_data
);
   int n_byte = 0;

   initial
   begin
      cam_pclk  = 1'b0;
      cam_vsync = 1'b0;
      cam_href  = 1'b0;
      cam_field = 1'b0;
      cam_data  = 8'hFF;
   end

   // The pixel clock only runs inside these tasks, as a real sensor
   // may stop it between frames.
   task automatic tick();
      #40 cam_pclk = 1'b1;
      #40 cam_pclk = 1'b0;
   endtask : tick

   task automatic frame_edge(input logic fld);
      cam_field = fld;
      cam_vsync = 1'b1;
      tick();
      tick();
      cam_vsync = 1'b0;
      tick();
      n_byte = 0;
   endtask : frame_edge

   // Outside a line the data bus shows the inverse of the last byte.
   task automatic line(input int nb);
      cam_href = 1'b1;
      repeat (nb)
      begin
         cam_data = 8'h20 + n_byte[7:0];
         n_byte++;
         tick();
      end
      cam_href = 1'b0;
      cam_data = ~cam_data;
      tick();
   endtask : line
endmodule : ccc_sensor_model

// ---- sim/ccc_capture_ctrl_tb.sv ----
`timescale 1ns/10ps
`include "ccc_consts.svh"
module ccc_capture_ctrl_tb
   import ccc_pkg::*;
;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] rst;
      logic [31:0] wd;
      logic [31:0] exp;
      logic        err;
   } ccc_row_t;
   logic        pclk, presetn, psel, penable, pwrite, ref_clk_24m;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, pix_addr, pix_data, rd;
   logic        pready, pslverr, pix_valid, er;
   logic [1:0]  pix_fifo;
   logic        cam_pclk, cam_vsync, cam_href, cam_field;
   logic [7:0]  cam_data;
   logic [31:0] q_data[$];
   logic [31:0] q_addr[$];
   int          failures = 0;
   int          n_compared = 0;
   int          v0;
   realtime     t0, t1;
   ccc_row_t    rows[8] = '{
      '{`CCC_OFF_FORMAT, `CCC_RST_FORMAT, 32'hFFFFFFFF, `CCC_M_FORMAT, 1'b0},
      '{`CCC_OFF_SCALE, 32'h0, 32'hFFFFFFFF, 32'h1, 1'b0},
      '{`CCC_OFF_FIFO0_ADDR, 32'h0, 32'h10000000, 32'h10000000, 1'b0},
      '{`CCC_OFF_FIFO1_ADDR, 32'h0, 32'h20000004, 32'h20000004, 1'b0},
      '{`CCC_OFF_FIFO2_ADDR, 32'h0, 32'h3000000C, 32'h3000000C, 1'b0},
      '{`CCC_OFF_STATUS, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0},
      '{`CCC_OFF_FRM_INTERVAL, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0},
      '{12'h100, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1}};

   ccc_capture_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_clk_24m(ref_clk_24m), .cam_pclk(cam_pclk),
      .cam_vsync(cam_vsync), .cam_href(cam_href), .cam_field(cam_field),
      .cam_data(cam_data), .pix_valid(pix_valid), .pix_fifo(pix_fifo),
      .pix_addr(pix_addr), .pix_data(pix_data));
   ccc_sensor_model u_sensor (.cam_pclk(cam_pclk), .cam_vsync(cam_vsync),
      .cam_href(cam_href), .cam_field(cam_field), .cam_data(cam_data));

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      ref_clk_24m = 1'b0;
      forever #20.833 ref_clk_24m = ~ref_clk_24m;
   end
   initial
   begin
      repeat (100000) @(posedge pclk);
      failures++;
      final_report();
   end
   always @(posedge pclk)
      if (pix_valid === 1'b1)
      begin
         q_data.push_back(pix_data);
         q_addr.push_back(pix_addr);
      end
   always @(posedge cam_vsync)
   begin
      t0 = t1;
      t1 = $realtime;
   end

   task final_report();
      if (failures == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1)
      begin
         failures++;
         final_report();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic run_frame(input logic fld, input int nl, input int nb);
      q_data.delete();
      q_addr.delete();
      u_sensor.frame_edge(fld);
      repeat (nl) u_sensor.line(nb);
      u_sensor.frame_edge(fld);
      repeat (20) @(posedge pclk);
   endtask : run_frame

   initial
   begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         apb(1'b0, rows[i].a, 32'h0);
         check(rd, rows[i].rst);
         apb(1'b1, rows[i].a, rows[i].wd);
         apb(1'b0, rows[i].a, 32'h0);
         check(rd, rows[i].exp);
         check({31'h0, er}, {31'h0, rows[i].err});
      end
      apb(1'b0, `CCC_OFF_ACC_LIVE, 32'h0);
      v0 = rd[23:0];
      repeat (100) @(posedge pclk);
      apb(1'b0, `CCC_OFF_ACC_LIVE, 32'h0);
      v0 = rd[23:0] - v0;
      check(v0 inside {[22:27]}, 1'b1);
      apb(1'b1, `CCC_OFF_SCALE, 32'h0);
      apb(1'b1, `CCC_OFF_FORMAT, 32'h00000800);
      apb(1'b1, `CCC_OFF_ACC_LIVE, 32'h0);
      apb(1'b1, `CCC_OFF_CONTROL, 32'h1);
      run_frame(1'b0, 2, 4);
      check(q_data.size(), 8);
      foreach (q_data[i])
         check(q_data[i][7:0], 8'h20 + i);
      check(q_addr[0], 32'h10000000);
      apb(1'b0, `CCC_OFF_STATUS, 32'h0);
      check(rd[1], 1'b1);
      apb(1'b0, `CCC_OFF_EVENTS, 32'h0);
      check(rd[1], 1'b1);
      apb(1'b0, `CCC_OFF_ACC_LIVE, 32'h0);
      check(rd[31:24], 8'h02);
      apb(1'b0, `CCC_OFF_FRM_INTERVAL, 32'h0);
      v0 = int'(rd[23:0]) - int'((t1 - t0) * 0.024);
      check(v0 inside {[-3:3]}, 1'b1);
      // Still request with video dropped: video ends, one still frame.
      apb(1'b1, `CCC_OFF_EVENTS, 32'h3);
      apb(1'b1, `CCC_OFF_CONTROL, 32'h2);
      q_data.delete();
      u_sensor.frame_edge(1'b0);
      apb(1'b0, `CCC_OFF_STATUS, 32'h0);
      check(rd[1:0], 2'b01);
      apb(1'b0, `CCC_OFF_EVENTS, 32'h0);
      check(rd[0], 1'b1);
      apb(1'b1, `CCC_OFF_EVENTS, 32'h3);
      u_sensor.line(4);
      u_sensor.frame_edge(1'b0);
      repeat (20) @(posedge pclk);
      check(q_data.size(), 4);
      apb(1'b0, `CCC_OFF_STATUS, 32'h0);
      check(rd[1:0], 2'b00);
      apb(1'b0, `CCC_OFF_EVENTS, 32'h0);
      check(rd[0], 1'b1);
      apb(1'b1, `CCC_OFF_FORMAT, 32'h5A060800);
      apb(1'b1, `CCC_OFF_CONTROL, 32'h1);
      run_frame(1'b0, 1, 6);
      check(q_data.size(), 2);
      check(q_data[0], 32'h5A202122);
      check(q_data[1], 32'h5A232425);
      foreach (rows[i])
      begin
         if (i < 4)
         begin
            apb(1'b1, `CCC_OFF_FORMAT,
                {8'h00, 8'(8'h03 + 8'h3B * i), 16'h0800});
            run_frame(1'b0, 1, 4);
            check(q_data.size(), 0);
         end
      end
      apb(1'b1, `CCC_OFF_FORMAT, 32'h0);
      run_frame(1'b1, 1, 4);
      check(q_data.size(), 0);
      apb(1'b0, `CCC_OFF_STATUS, 32'h0);
      check(rd[2], 1'b1);
      apb(1'b1, `CCC_OFF_FORMAT, 32'h00000400);
      run_frame(1'b1, 1, 4);
      check(q_data.size(), 4);
      apb(1'b1, `CCC_OFF_SCALE, 32'h1);
      run_frame(1'b1, 2, 4);
      check(q_data.size(), 2);
      apb(1'b1, `CCC_OFF_FORMAT, 32'h00303A00);
      run_frame(1'b0, 1, 4);
      check(q_addr[0], 32'h20096003);
      check(q_addr[1], 32'h10095FFF);
      check(q_addr[2], 32'h3009600B);
      check(q_addr[3], 32'h10095FFE);
      apb(1'b1, `CCC_OFF_FORMAT, 32'h00320800);
      apb(1'b1, `CCC_OFF_CONTROL, 32'h5);
      u_sensor.frame_edge(1'b0);
      apb(1'b1, `CCC_OFF_EVENTS, 32'h3);
      u_sensor.frame_edge(1'b0);
      apb(1'b0, `CCC_OFF_EVENTS, 32'h0);
      check(rd[1], 1'b0);
      u_sensor.frame_edge(1'b0);
      apb(1'b0, `CCC_OFF_EVENTS, 32'h0);
      check(rd[1], 1'b1);
      apb(1'b1, `CCC_OFF_ACC_LIVE, 32'h0);
      repeat (257) u_sensor.frame_edge(1'b0);
      repeat (20) @(posedge pclk);
      apb(1'b1, `CCC_OFF_ACC_LIVE, 32'h01000000);
      apb(1'b0, `CCC_OFF_ACC_LIVE, 32'h0);
      check(rd[31:24], 8'h01);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CCC_OFF_FORMAT, 32'h0);
      check(rd, `CCC_RST_FORMAT);
      apb(1'b0, `CCC_OFF_ACC_LIVE, 32'h0);
      check(rd[31:24], 8'h00);
      final_report();
   end
endmodule : ccc_capture_ctrl_tb
